/* pvo_host.sv */
// host model issuing command strobes
// assumes the block acks within two cycles of a strobe
`timescale 1ns/10ps
module pvo_host (
  input  wire         clk,
  input  wire         cmd_ack,
  input  wire  [15:0] cmd_rdata,
  output logic        cmd_write,
  output logic        cmd_read,
  output logic [7:0]  cmd_code,
  output logic [1:0]  cmd_page,
  output logic [15:0] cmd_wdata
);
  initial {cmd_write, cmd_read, cmd_code, cmd_page, cmd_wdata} = 28'h0;
  task automatic xfer(input logic w, input logic [7:0] c, input logic [1:0] p, input logic [15:0] d,
                      output logic [15:0] q);
    @(posedge clk);
    {cmd_write, cmd_read, cmd_code, cmd_page, cmd_wdata} <= {w, !w, c, p, d};
    @(posedge clk);
    // data inverted once released so a stale word never looks valid
    {cmd_write, cmd_read, cmd_wdata} <= {2'h0, ~d};
    #1 if (!cmd_ack) @(posedge clk) #1;
    q = cmd_rdata;
  endtask
endmodule

/* pvo_options_regs.v */
// option registers for a dual-channel step-down controller with valley and float-drive logic
// assumes a same-clock command port from the serial bus engine and nvm defaults loaded at reset
//
// Overview of operation
// - spare register bits 11..0 are trim; host writes never change them.
// - spare register powers up with top nibble 3; user bits take nvm defaults.
// - with limit enabled, valley active at most 3 clocks, then 4 clocks blocked.
// - with limit disabled, valley stays active while trigger persists.
// - on entering float, drive pin to selected level about 20 ns, then release.
// - bit 13 forces channel 2 float level low; else level follows stage mode.
// - bit 12 does the same for channel 1 float level.
// - options register resets to bits 14..10 set, others clear.
// - options high byte shared, all read/write and saveable.
`timescale 1ns/10ps
`include "pvo_regs.vh"

module pvo_options_regs (
  input  wire        clk,
  input  wire        reset,
  input  wire        clk_en,
  input  wire        nvm_valid,
  input  wire [15:0] nvm_spare,
  input  wire [15:0] nvm_options,
  input  wire [1:0]  nvm_low_ch,
  input  wire [11:0] trim_value,
  input  wire        cmd_write,
  input  wire        cmd_read,
  input  wire [7:0]  cmd_code,
  input  wire [1:0]  cmd_page,
  input  wire [15:0] cmd_wdata,
  input  wire [1:0]  valley_trigger,
  input  wire [1:0]  float_request,
  output reg  [15:0] cmd_rdata,
  output reg         cmd_ack,
  output reg  [15:0] spare_valley_hiz_config,
  output reg  [15:0] controller_options,
  output reg  [1:0]  valley_active,
  output reg  [1:0]  float_drive_en,
  output reg  [1:0]  float_level_low
);

  ////////////////////////////////////////////////////////////////////////
  // register state and next values
  reg  [3:0]  user_reg;
  reg  [3:0]  user_next;
  reg  [11:0] trim_reg;
  reg  [11:0] trim_next;
  reg  [7:0]  high_reg;
  reg  [7:0]  high_next;
  reg  [1:0]  mask_ch1_reg;
  reg  [1:0]  mask_ch1_next;
  reg  [1:0]  mask_ch2_reg;
  reg  [1:0]  mask_ch2_next;
  reg         load_done_reg;
  reg         load_done_next;
  reg         ack_next;
  reg  [15:0] rdata_next;
  reg  [15:0] spare_next;
  reg  [15:0] options_next;

  ////////////////////////////////////////////////////////////////////////
  // decode of the command port
  wire        hit_spare;
  wire        hit_opt;
  wire        wr_spare;
  wire        wr_opt;
  wire        wr_ch1;
  wire        wr_ch2;
  wire        page_ch1;
  wire        page_ch2;
  wire        nvm_take;
  wire        smart;
  wire        unlimited;
  wire [1:0]  force_low;
  wire [15:0] spare_word;
  wire [7:0]  low_ch1_byte;
  wire [7:0]  low_ch2_byte;
  wire [7:0]  low_sel_byte;

  assign hit_spare = (cmd_code == `PVO_CMD_SPARE);
  assign hit_opt   = (cmd_code == `PVO_CMD_OPTIONS);
  // page 3 reaches both channels; page 2 is treated as channel 1
  assign page_ch1  = !cmd_page[0] || (cmd_page == 2'h3);
  assign page_ch2  = cmd_page[0];
  // the nvm image is taken once and wins over a write in the same cycle
  assign nvm_take  = !load_done_reg && nvm_valid;
  assign wr_spare  = cmd_write && !nvm_take && hit_spare;
  assign wr_opt    = cmd_write && !nvm_take && hit_opt;
  assign wr_ch1    = wr_opt && page_ch1;
  assign wr_ch2    = wr_opt && page_ch2;

  ////////////////////////////////////////////////////////////////////////
  // fields that steer the channel logic
  assign smart        = high_reg[`PVO_BIT_SMART - 8];
  assign unlimited    = user_reg[`PVO_BIT_VALLEY_DIS - 12];
  assign force_low[0] = user_reg[`PVO_BIT_CH1_FLOAT - 12];
  assign force_low[1] = user_reg[`PVO_BIT_CH2_FLOAT - 12];

  ////////////////////////////////////////////////////////////////////////
  // read-back words
  // bit 15 of the spare word is never set, so it always reads 0
  assign spare_word   = {user_reg, trim_reg};
  assign low_ch1_byte = {6'h00, mask_ch1_reg};
  assign low_ch2_byte = {6'h00, mask_ch2_reg};
  assign low_sel_byte = page_ch2 ? low_ch2_byte : low_ch1_byte;

  ////////////////////////////////////////////////////////////////////////
  // next register contents
  always @* begin
    user_next      = user_reg;
    trim_next      = trim_reg;
    high_next      = high_reg;
    mask_ch1_next  = mask_ch1_reg;
    mask_ch2_next  = mask_ch2_reg;
    load_done_next = load_done_reg;
    if (nvm_take) begin
      load_done_next = 1'b1;
      // stored user bits replace the power-up nibble
      user_next      = {1'b0, nvm_spare[`PVO_SPARE_USER_MSB - 1:`PVO_SPARE_USER_LSB]};
      trim_next      = trim_value;
      high_next      = nvm_options[15:8];
      mask_ch1_next  = nvm_low_ch;
      mask_ch2_next  = nvm_low_ch;
    end
    if (wr_spare) begin
      user_next = {1'b0, cmd_wdata[`PVO_SPARE_USER_MSB - 1:`PVO_SPARE_USER_LSB]};
    end
    if (wr_opt) begin
      high_next = cmd_wdata[15:8];
    end
    // paged low byte, two writable bits
    if (wr_ch1) begin
      mask_ch1_next = cmd_wdata[1:0] & `PVO_OPT_LOW_MASK;
    end
    if (wr_ch2) begin
      mask_ch2_next = cmd_wdata[1:0] & `PVO_OPT_LOW_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // command response and mirrors
  always @* begin
    ack_next   = cmd_write | cmd_read;
    rdata_next = cmd_rdata;
    if (cmd_read) begin
      case (cmd_code)
        `PVO_CMD_SPARE:   rdata_next = spare_word;
        `PVO_CMD_OPTIONS: rdata_next = {high_reg, low_sel_byte};
        default:          rdata_next = 16'h0000;
      endcase
    end
    spare_next   = spare_word;
    // the mirror can show one page only; channel 1 was chosen
    options_next = {high_reg, low_ch1_byte};
  end

  ////////////////////////////////////////////////////////////////////////
  // register flops
  always @(posedge clk) begin
    if (reset) begin
      user_reg                <= `PVO_SPARE_TOP_RST;
      trim_reg                <= `PVO_TRIM_RST;
      high_reg                <= `PVO_OPT_HIGH_RST;
      mask_ch1_reg            <= `PVO_OPT_MASK_RST;
      mask_ch2_reg            <= `PVO_OPT_MASK_RST;
      load_done_reg           <= 1'b0;
      cmd_ack                 <= 1'b0;
      cmd_rdata               <= 16'h0000;
      spare_valley_hiz_config <= {`PVO_SPARE_TOP_RST, `PVO_TRIM_RST};
      controller_options      <= `PVO_OPT_RST;
    end else if (clk_en) begin
      user_reg                <= user_next;
      trim_reg                <= trim_next;
      high_reg                <= high_next;
      mask_ch1_reg            <= mask_ch1_next;
      mask_ch2_reg            <= mask_ch2_next;
      load_done_reg           <= load_done_next;
      cmd_ack                 <= ack_next;
      cmd_rdata               <= rdata_next;
      spare_valley_hiz_config <= spare_next;
      controller_options      <= options_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // per-channel valley limiter and float driver
  localparam [1:0] ST_IDLE  = 2'h0;
  localparam [1:0] ST_ACT   = 2'h1;
  localparam [1:0] ST_BLOCK = 2'h2;
  // drive time is rounded up to whole clocks so it is never shorter than asked
  localparam integer DRIVE_CYC_INT = `PVO_DRIVE_CYC;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_ch
      reg  [1:0] state_reg;
      reg  [1:0] state_next;
      reg  [1:0] cnt_reg;
      reg  [1:0] cnt_next;
      reg  [3:0] drv_reg;
      reg  [3:0] drv_next;
      reg        prev_reg;
      reg        active_next;
      reg        drive_next;
      wire       trig;
      wire       float_rise;
      wire       at_limit;

      assign trig       = valley_trigger[ch];
      assign float_rise = float_request[ch] && !prev_reg;
      assign at_limit   = (cnt_reg == `PVO_VALLEY_CLKS);

      always @* begin
        state_next  = state_reg;
        cnt_next    = cnt_reg;
        active_next = 1'b0;
        case (state_reg)
          ST_IDLE: begin
            if (trig) begin
              state_next  = ST_ACT;
              cnt_next    = 2'h1;
              active_next = 1'b1;
            end
          end
          ST_ACT: begin
            if (unlimited) begin
              active_next = trig;
              if (!trig) begin
                state_next = ST_IDLE;
              end else if (!at_limit) begin
                cnt_next = cnt_reg + 2'h1;
              end
            end else begin
              // three clocks then blocked; an early drop is blocked too
              active_next = trig && !at_limit;
              if (at_limit || !trig) begin
                state_next = ST_BLOCK;
                cnt_next   = 2'h1;
              end else begin
                cnt_next = cnt_reg + 2'h1;
              end
            end
          end
          ST_BLOCK: begin
            if (at_limit) begin
              state_next = ST_IDLE;
            end else begin
              cnt_next = cnt_reg + 2'h1;
            end
          end
          default: begin
            state_next = ST_IDLE;
          end
        endcase
      end

      always @* begin
        drv_next   = drv_reg;
        drive_next = 1'b0;
        if (float_rise) begin
          drv_next   = DRIVE_CYC_INT[3:0];
          drive_next = 1'b1;
        end else begin
          if (drv_reg != 4'h0) begin
            drv_next = drv_reg - 4'h1;
          end
          drive_next = (drv_reg > 4'h1);
        end
      end

      always @(posedge clk) begin
        if (reset) begin
          state_reg           <= ST_IDLE;
          cnt_reg             <= 2'h0;
          drv_reg             <= 4'h0;
          prev_reg            <= 1'b0;
          valley_active[ch]   <= 1'b0;
          float_drive_en[ch]  <= 1'b0;
          float_level_low[ch] <= 1'b1;
        end else if (clk_en) begin
          state_reg           <= state_next;
          cnt_reg             <= cnt_next;
          drv_reg             <= drv_next;
          prev_reg            <= float_request[ch];
          valley_active[ch]   <= active_next;
          float_drive_en[ch]  <= drive_next;
          float_level_low[ch] <= force_low[ch] | smart;
        end
      end

    end
  endgenerate

endmodule

/* pvo_options_regs_bench.sv */
// self-checking bench for the option register block
// assumes pvo_host drives commands and pvo_props is bound
`timescale 1ns/10ps
module pvo_options_regs_bench;
  logic        clk, reset, cmd_write, cmd_read, cmd_ack;
  logic [1:0]  valley_trigger, float_request, valley_active, float_drive_en, float_level_low, cmd_page;
  logic [7:0]  cmd_code;
  logic [11:0] trim_value;
  logic [15:0] cmd_wdata, cmd_rdata, q, spare_mirror, opt_mirror, nvm_spare;
  int          n_errors = 0, num_checks = 0, cyc = 0, k;
  pvo_options_regs pvo_options_regs_inst (.clk, .reset, .clk_en(1'b1), .nvm_valid(1'b1), .nvm_spare,
    .nvm_options(16'h7C00), .nvm_low_ch(2'h0), .trim_value, .cmd_write, .cmd_read, .cmd_code, .cmd_page,
    .cmd_wdata, .valley_trigger, .float_request, .cmd_rdata, .cmd_ack, .spare_valley_hiz_config(spare_mirror),
    .controller_options(opt_mirror), .valley_active, .float_drive_en, .float_level_low);
  pvo_host pvo_host_inst (.clk, .cmd_ack, .cmd_rdata, .cmd_write, .cmd_read, .cmd_code, .cmd_page, .cmd_wdata);
  task chk(input logic [15:0] s, e);
    num_checks++;
    if (s !== e) begin
      n_errors++;
      $display("ERROR %0t seen %h want %h", $time, s, e);
    end
  endtask
  task wr(input logic [7:0] c, input logic [1:0] p, input logic [15:0] d);
    pvo_host_inst.xfer(1'b1, c, p, d, q);
    chk(cmd_ack, 16'h0001);
  endtask
  task rd(input logic [7:0] c, input logic [1:0] p, input logic [15:0] e);
    pvo_host_inst.xfer(1'b0, c, p, 16'h0000, q);
    chk(q, e);
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 500) begin
      n_errors++;
      end_sim();
    end
  end
  initial begin
    {reset, valley_trigger, float_request} = 5'h10;
    trim_value = 12'hA5C;
    nvm_spare = 16'h3000;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    rd(8'hE0, 2'h0, 16'h3A5C);
    rd(8'hE5, 2'h0, 16'h7C00);
    wr(8'hE0, 2'h0, 16'hFFFF);
    rd(8'hE0, 2'h0, 16'h7A5C);
    chk(spare_mirror, 16'h7A5C);
    @(posedge clk);
    valley_trigger <= 2'h1;
    repeat (8) @(posedge clk);
    #1 chk(valley_active, 16'h0001);
    @(posedge clk);
    valley_trigger <= 2'h0;
    $display("test 1 done");
    wr(8'hE0, 2'h0, 16'h0000);
    rd(8'hE0, 2'h0, 16'h0A5C);
    chk(float_level_low, 16'h0000);
    @(posedge clk);
    {valley_trigger, float_request} <= 4'h7;
    k = 0;
    // valley counts once, each float channel four times
    repeat (6) begin
      @(posedge clk);
      #1 k += valley_active[0] + 4 * (float_drive_en[0] + float_drive_en[1]);
    end
    chk(k[15:0], 16'h001B);
    @(posedge clk);
    {valley_trigger, float_request} <= 4'h0;
    wr(8'hE5, 2'h0, 16'h0100);
    rd(8'hE5, 2'h0, 16'h0100);
    chk(opt_mirror, 16'h0100);
    chk(float_level_low, 16'h0003);
    $display("test 2 done");
    wr(8'hE5, 2'h3, 16'hFFFF);
    rd(8'hE5, 2'h1, 16'hFF03);
    wr(8'hE5, 2'h1, 16'h0000);
    rd(8'hE5, 2'h1, 16'h0000);
    rd(8'hE5, 2'h0, 16'h0003);
    chk(opt_mirror, 16'h0003);
    rd(8'hE7, 2'h0, 16'h0000);
    $display("test 3 done");
    @(posedge clk);
    reset <= 1'b1;
    nvm_spare <= 16'h5000;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rd(8'hE0, 2'h0, 16'h5A5C);
    rd(8'hE5, 2'h0, 16'h7C00);
    chk(spare_mirror, 16'h5A5C);
    $display("test 4 done");
    end_sim();
  end
endmodule

/* pvo_props.sv */
// assertions on the option register block ports
// assumes a bind onto pvo_options_regs
`timescale 1ns/10ps
module pvo_props (
  input wire        clk,
  input wire        reset,
  input wire [7:0]  cmd_code,
  input wire        cmd_read,
  input wire [11:0] trim_value,
  input wire [15:0] cmd_rdata,
  input wire [15:0] spare_valley_hiz_config,
  input wire [15:0] controller_options,
  input wire [1:0]  valley_trigger,
  input wire [1:0]  valley_active,
  input wire [1:0]  float_request,
  input wire [1:0]  float_drive_en,
  input wire [1:0]  float_level_low
);
  wire [15:0] sp = spare_valley_hiz_config;
  wire        lv = sp[13] | controller_options[8];
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence v_run; valley_active[0] [*3]; endsequence
  sequence f_pulse; float_drive_en[0] [*3] ##1 !float_drive_en[0]; endsequence
  trim_keep_a: assert property (cmd_read && cmd_code == 8'hE0 |=> cmd_rdata[11:0] == $past(trim_value))
    else $error("trim bits changed");
  low_ro_a: assert property (cmd_read && cmd_code == 8'hE5 |=> cmd_rdata[7:2] == 6'h00)
    else $error("read-only options bits set");
  valley_cap_a: assert property (!sp[14] throughout v_run |=> !valley_active[0])
    else $error("valley over 3 clocks");
  valley_gap_a: assert property (!sp[14] && $fell(valley_active[0]) |-> !valley_active[0] [*3])
    else $error("valley retriggered early");
  valley_hold_a: assert property (sp[14] && valley_active[0] && valley_trigger[0] |=> valley_active[0])
    else $error("valley dropped");
  float_pulse_a: assert property ($rose(float_request[0]) |=> f_pulse)
    else $error("float drive not 3 cycles");
  float_level_a: assert property (lv == $past(lv) |-> float_level_low[1] == lv)
    else $error("ch2 float level wrong");
  float_level1_a: assert property (float_level_low[0] == (sp[12] | controller_options[8]))
    else $error("ch1 float level wrong");
  reset_val_a: assert property ($fell(reset) |-> sp[15:12] == 4'h3 && controller_options == 16'h7C00)
    else $error("power-up value wrong");
endmodule
bind pvo_options_regs pvo_props pvo_props_inst (.*);

/* pvo_regs.vh */
// constants for the valley/float option register block
// assumes a host command port that presents a command code and 16-bit word
`ifndef PVO_REGS_VH
`define PVO_REGS_VH
`define PVO_CMD_SPARE       8'hE0
`define PVO_CMD_OPTIONS     8'hE5
`define PVO_SPARE_TOP_RST   4'h3
`define PVO_SPARE_USER_MSB  15
`define PVO_SPARE_USER_LSB  12
`define PVO_BIT_VALLEY_DIS  14
`define PVO_BIT_CH2_FLOAT   13
`define PVO_BIT_CH1_FLOAT   12
`define PVO_TRIM_RST        12'h000
`define PVO_OPT_RST         16'h7C00
`define PVO_OPT_HIGH_RST    8'h7C
`define PVO_OPT_MASK_RST    2'h0
`define PVO_OPT_HIGH_MASK   16'hFF00
`define PVO_OPT_LOW_MASK    2'h3
`define PVO_BIT_SMART       8
`define PVO_VALLEY_CLKS     2'h3
`define PVO_DRIVE_NS        20
`define PVO_CLK_NS          8
`define PVO_DRIVE_CYC       ((`PVO_DRIVE_NS + `PVO_CLK_NS - 1) / `PVO_CLK_NS)
`endif
